// ===== common/dli_pkg.sv
// Package for the die link initiator status bank: register map, field
// positions, reset values and the carriers of the sequencer interface.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`default_nettype none

package dli_pkg;

	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_LINK_CONTROL_ZERO = 4'h0;
	localparam logic [3:0] IDX_LINK_ERROR_STATUS = 4'h2;
	localparam logic [3:0] IDX_LINK_PIN_BUSY_STATUS = 4'h3;
	localparam logic [3:0] IDX_TRANSACTION_ADDRESS_CAPTURE = 4'h4;

	// Control register fields
	localparam int POS_LINK_ENABLE = 7;
	localparam int POS_WAIT_LIMIT_HI = 3;

	// Error status fields
	localparam int POS_ERROR_SUMMARY = 7;
	localparam int POS_ACK_LINE_FAULT = 6;
	localparam int POS_CANCEL = 5;
	localparam int POS_TIMEOUT = 4;
	localparam int POS_TARGET_ERROR = 3;
	localparam int POS_PARITY_ERROR = 2;
	localparam int POS_PARITY_HI = 1;
	localparam int POS_PARITY_LO = 0;

	// Pin and busy status fields
	localparam int POS_TARGET_IRQ_MIRROR = 7;
	localparam int POS_INITIATOR_BUSY = 6;

	// Address capture fields
	localparam int POS_CAPTURE_DIRECTION = 15;
	localparam int POS_CAPTURE_BYTE_SIZE = 14;
	localparam int POS_CAPTURE_NONBLOCKING = 12;
	localparam int POS_CAPTURE_ADDR_HI = 7;

	// Reset values
	localparam logic [7:0] RST_LINK_CONTROL_ZERO = 8'h00;
	localparam logic [5:0] RST_ERROR_DETAIL = 6'h00;
	localparam logic [15:0] RST_ADDRESS_CAPTURE = 16'h0000;
	localparam logic [3:0] RST_ACK_WAIT_LIMIT = 4'h0;

	// Lines on the link data bus
	localparam int LINK_LINES = 8;

	// Transaction request from the sequencer
	typedef struct packed {
		logic capture_direction;   // 1 read, 0 write
		logic capture_byte_size;   // 1 byte, 0 halfword
		logic capture_nonblocking; // 1 non-blocking window
		logic [7:0] addr;          // Window-relative address
	} dli_req_s;

	// Acknowledge cycle sample from the sequencer
	typedef struct packed {
		logic [LINK_LINES-1:0] lines; // Data lines during acknowledge
		logic target_err;             // Target error signal
		logic [1:0] parity_rx;        // Parity sent by the target
		logic [1:0] parity_calc;      // Parity computed locally
	} dli_ack_s;

	// Transaction progress
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_XFER = 3'b010,
		ST_WAIT = 3'b100
	} dli_state_e;

endpackage : dli_pkg

`default_nettype wire

// ===== design/dli_status_bank.sv
// Status and transaction-capture registers of a die link initiator.
// Assumes a classic Wishbone master, a sequencer on clk_i that presents
// requests and acknowledge samples, and a link clock and target interrupt
// that arrive from outside and are synchronised here.
//
// Notes on behaviour
// R1: Summary error flag, bit 7, sets on any of the five detail errors.
// R2: Writing one clears the summary flag; writing zero leaves it.
// R3: Error interrupt follows the summary flag with no local mask.
// R4: Bit 6 sets when any data line reads low in the acknowledge cycle.
// R5: Detail flags are read-only and clear with the summary flag.
// R6: Bit 5 sets when a request is dropped for idle while error pends.
// R7: Bit 4 sets when the target fails to acknowledge in time.
// R8: Bit 3 sets when the target error signal shows during acknowledge.
// R9: Bit 2 sets when received parity differs from computed parity.
// R10: Bits 1 and 0 hold the received parity bits, read-only.
// R11: Status one bit 7 mirrors the target interrupt pin, not writable.
// R12: Target clears its own interrupt; no clear exists here.
// R13: Status one bit 6 reads one while a transaction is in progress.
// R14: Address capture loads at the start of every new transaction.
// R15: Capture bit 15 is direction, one for read.
// R16: Capture bit 14 is size, one for an 8-bit transfer.
// R17: Capture bit 12 is mode, one for non-blocking.
// R18: Capture bits 7:0 hold the window-relative address.
// R19: After link enable is set, write-once configuration writes are ignored.
// R20: While the summary flag is set, capture freezes and requests become idle.
// R21: Timeout comes after the programmed link clock cycles without acknowledge.
// R22: Target sends two parity bits in the final acknowledge cycle.
// R23: Reserved bits of status one and the capture read as zero.
`default_nettype none

module dli_status_bank
	import dli_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Sequencer side, same clock
	input wire logic req_valid_i,
	input wire dli_pkg::dli_req_s req_i,
	input wire logic last_cycle_i,
	input wire logic ack_valid_i,
	input wire dli_pkg::dli_ack_s ack_i,
	output logic start_o,
	output logic idle_cmd_o,
	// Pins from outside the clock domain
	input wire logic link_clock_i,
	input wire logic target_irq_pin_i,
	// Configuration and status toward the rest of the initiator
	output logic link_enable_o,
	output logic [3:0] ack_wait_limit_o,
	output logic initiator_busy_o,
	output logic error_irq_o
);
	import dli_pkg::*;

	dli_state_e state;
	logic [7:0] control;
	logic error_summary_flag;
	logic [5:1] detail; // ack fault, cancel, timeout, target err, parity err
	logic [1:0] received_parity;
	logic [15:0] capture;
	logic [1:0] link_clock_sync;
	logic link_clock_prev;
	logic [1:0] irq_sync;
	logic [4:0] wait_count;
	logic wb_req;
	logic wb_wr;
	logic [4:0] wb_word;
	logic [3:0] wb_idx;
	logic summary_clear;
	logic ack_fault;
	logic parity_fault;
	logic target_fault;
	logic link_edge;
	logic timeout_hit;
	logic accept;
	logic cancel;
	logic detail_event;
	logic next_error_summary;

	// Word index from a byte address; upper bits must be zero to match
	function automatic logic [4:0] word_index(input logic [5:0] adr);
		word_index = {adr[5], adr[5:2]};
	endfunction : word_index

	// Bus request decode
	assign wb_req = wb_cyc_i & wb_stb_i;
	// Writes land on the acknowledge edge, while the master still holds the request
	assign wb_wr = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign wb_word = word_index(wb_adr_i);
	assign wb_idx = wb_word[3:0];

	// R2: one-to-clear summary
	assign summary_clear = wb_wr & (wb_idx == IDX_LINK_ERROR_STATUS)
		& wb_dat_i[POS_ERROR_SUMMARY];

	// R4: any low data line
	assign ack_fault = ack_valid_i & ~(&ack_i.lines);
	// R9: parity compare
	assign parity_fault = ack_valid_i & (ack_i.parity_rx != ack_i.parity_calc);
	// R8: error signal in the acknowledge cycle
	assign target_fault = ack_valid_i & ack_i.target_err;

	// R20: requests pass only with no error pending
	// A request during a transfer is not started, and is cancelled only while an error pends
	assign accept = req_valid_i & state[0] & ~error_summary_flag;
	// R6: dropped request
	assign cancel = req_valid_i & error_summary_flag;

	// Rising edge of the synchronised link clock
	assign link_edge = link_clock_sync[1] & ~link_clock_prev;

	// R21: wait limit passed in link clock cycles
	assign timeout_hit = state[2] & ~ack_valid_i & link_edge
		& (wait_count == {1'b0, control[POS_WAIT_LIMIT_HI:0]});

	// R1: any of the five detail events
	assign detail_event = ack_fault | parity_fault | cancel | timeout_hit | target_fault;

	// R1: summary of all detail errors, set wins over clear
	always_comb
	begin
		next_error_summary = error_summary_flag & ~summary_clear;
		if (detail_event)
			next_error_summary = 1'b1;
	end

	// Wishbone acknowledge, one cycle after request, dropped after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req & ~wb_ack_o;
	end

	// Read data, unmapped indices read zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_req & ~wb_ack_o & ~wb_word[4])
		begin
			unique case (wb_idx)
				IDX_LINK_CONTROL_ZERO:
					wb_dat_o <= {24'h00_0000, control};
				IDX_LINK_ERROR_STATUS:
					wb_dat_o <= {24'h00_0000, error_summary_flag, detail[5:1],
						received_parity};
				// R23: reserved bits read zero
				IDX_LINK_PIN_BUSY_STATUS:
					wb_dat_o <= {24'h00_0000, irq_sync[1], initiator_busy_o, 6'h00};
				IDX_TRANSACTION_ADDRESS_CAPTURE:
					wb_dat_o <= {16'h0000, capture};
				default:
					wb_dat_o <= 32'h0000_0000;
			endcase
		end
		else
			wb_dat_o <= 32'h0000_0000;
	end

	// R19: configuration is write-once after enable
	// Enable and limit load together; the write that enables freezes both
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			control <= RST_LINK_CONTROL_ZERO;
		else if (wb_wr & (wb_idx == IDX_LINK_CONTROL_ZERO) & ~control[POS_LINK_ENABLE])
			control <= {wb_dat_i[POS_LINK_ENABLE], 3'h0, wb_dat_i[POS_WAIT_LIMIT_HI:0]};
	end

	// Summary error flag
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			error_summary_flag <= 1'b0;
		else
			error_summary_flag <= next_error_summary;
	end

	// R5: detail flags clear with summary, set wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			detail <= RST_ERROR_DETAIL[5:1];
		else
		begin
			// R4: ack line fault
			detail[5] <= ack_fault | (detail[5] & ~summary_clear);
			// R6: cancel
			detail[4] <= cancel | (detail[4] & ~summary_clear);
			// R7: timeout
			detail[3] <= timeout_hit | (detail[3] & ~summary_clear);
			// R8: target error
			detail[2] <= target_fault | (detail[2] & ~summary_clear);
			// R9: parity error
			detail[1] <= parity_fault | (detail[1] & ~summary_clear);
		end
	end

	// R10: received parity, R22: from the final acknowledge
	// Keeps latching while the buffers are frozen, so the last answer stays visible
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			received_parity <= 2'b00;
		else if (ack_valid_i)
			received_parity <= ack_i.parity_rx;
	end

	// R14: load capture on start, R20: frozen while error pends
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			capture <= RST_ADDRESS_CAPTURE;
		else if (accept)
		begin
			capture <= 16'h0000;
			// R15: direction
			capture[POS_CAPTURE_DIRECTION] <= req_i.capture_direction;
			// R16: size
			capture[POS_CAPTURE_BYTE_SIZE] <= req_i.capture_byte_size;
			// R17: mode
			capture[POS_CAPTURE_NONBLOCKING] <= req_i.capture_nonblocking;
			// R18: address
			capture[POS_CAPTURE_ADDR_HI:0] <= req_i.addr;
		end
	end

	// Transaction progress: idle, transfer, waiting for acknowledge
	// An early acknowledge ends the transfer before its last cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= ST_IDLE;
		else
		begin
			unique case (state)
				ST_IDLE:
					if (accept)
						state <= ST_XFER;
				ST_XFER:
					if (ack_valid_i)
						state <= ST_IDLE;
					else if (last_cycle_i)
						state <= ST_WAIT;
				ST_WAIT:
					if (ack_valid_i | timeout_hit)
						state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// R21: link clock edges since the last transfer cycle
	// One bit wider than the limit, so the count cannot wrap onto a match
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wait_count <= 5'h00;
		else if (~state[2])
			wait_count <= 5'h00;
		else if (link_edge)
			wait_count <= wait_count + 5'h01;
	end

	// Link clock synchroniser and edge history
	// Two flops settle the free clock; the third only keeps edge history
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			link_clock_sync <= 2'b00;
			link_clock_prev <= 1'b0;
		end
		else
		begin
			link_clock_sync <= {link_clock_sync[0], link_clock_i};
			link_clock_prev <= link_clock_sync[1];
		end
	end

	// R11: interrupt pin mirror, R12: cleared only by the target
	// Only the second flop feeds the status read, never the first
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_sync <= 2'b00;
		else
			irq_sync <= {irq_sync[0], target_irq_pin_i};
	end

	// Sequencer strobes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_o <= 1'b0;
			idle_cmd_o <= 1'b0;
		end
		else
		begin
			start_o <= accept;
			// R20: idle instead of a transaction
			idle_cmd_o <= cancel;
		end
	end

	// Status and configuration outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			initiator_busy_o <= 1'b0;
			error_irq_o <= 1'b0;
			link_enable_o <= 1'b0;
			ack_wait_limit_o <= RST_ACK_WAIT_LIMIT;
		end
		else
		begin
			// R13: busy while a transaction runs
			initiator_busy_o <= accept | (initiator_busy_o & ~(ack_valid_i | timeout_hit));
			// Taken from the next value, so the interrupt never lags the flag
			// R3: unmasked error interrupt
			error_irq_o <= next_error_summary;
			link_enable_o <= control[POS_LINK_ENABLE];
			ack_wait_limit_o <= control[POS_WAIT_LIMIT_HI:0];
		end
	end

endmodule : dli_status_bank

`default_nettype wire

// ===== dv/dli_target_model.sv
// Target model: last transfer cycle, acknowledge word and link clock.
// Assumes the bank's start and busy outputs on the same clock.
`default_nettype none
module dli_target_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic busy_i,
	input wire logic ack_en_i,
	input wire dli_pkg::dli_ack_s word_i,
	output logic last_o = 1'h0,
	output logic ack_valid_o = 1'h0,
	output dli_pkg::dli_ack_s ack_o = '0,
	output logic link_clock_o = 1'h0
);
	timeunit 1ns;
	timeprecision 100ps;
	import dli_pkg::*;
	int n = 0;
	int lk = 0;
	// Transfer steps counted from start
	always @(posedge clk_i)
	begin
		n <= start_i ? 1 : (n > 0 && n < 6) ? n + 1 : 0;
		last_o <= n == 3;
		// two parity bits with the answer
		ack_valid_o <= n == 5 && ack_en_i;
		ack_o <= n == 5 ? word_i : ~word_i; // Inverse when not answering
	end
	// Link clock of forty cycles, still while idle
	always @(posedge clk_i)
	begin
		lk <= busy_i && lk < 39 ? lk + 1 : 0;
		link_clock_o <= busy_i && lk >= 20;
	end
endmodule : dli_target_model
`default_nettype wire

// ===== dv/dli_status_bank_chk.sv
// Checker for the status bank, bound to its ports.
// Assumes the one-cycle registered Wishbone acknowledge.
`default_nettype none
module dli_status_bank_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic req_valid_i,
	input wire logic ack_valid_i,
	input wire dli_pkg::dli_ack_s ack_i,
	input wire logic start_o,
	input wire logic idle_cmd_o,
	input wire logic link_enable_o,
	input wire logic [3:0] ack_wait_limit_o,
	input wire logic initiator_busy_o,
	input wire logic error_irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import dli_pkg::*;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Error status write at its acknowledge
	sequence s_err_wr;
		wb_ack_o && wb_we_i && wb_adr_i[5:2] == IDX_LINK_ERROR_STATUS && wb_sel_i[0];
	endsequence
	// Request seen while idle and clean
	sequence s_req_ok;
		req_valid_i && !initiator_busy_o && !error_irq_o;
	endsequence
	a_clear_summary: assert property (s_err_wr ##0 (wb_dat_i[7] && !initiator_busy_o)
		|=> ##[0:1] !error_irq_o) else $error("summary not cleared");
	a_keep_summary: assert property (s_err_wr ##0 (!wb_dat_i[7] && error_irq_o)
		|=> error_irq_o) else $error("summary lost on zero write");
	a_line_fault: assert property (ack_valid_i && ack_i.lines != 8'hFF
		|-> ##[1:2] error_irq_o) else $error("line fault missed");
	a_target_error: assert property (ack_valid_i && ack_i.target_err
		|-> ##[1:2] error_irq_o) else $error("target error missed");
	a_parity_error: assert property (ack_valid_i && ack_i.parity_rx != ack_i.parity_calc
		|-> ##[1:2] error_irq_o) else $error("parity error missed");
	a_cancel_idle: assert property (req_valid_i && error_irq_o
		|=> idle_cmd_o && !start_o) else $error("request not cancelled");
	a_start_busy: assert property (s_req_ok
		|=> start_o && initiator_busy_o) else $error("request not started");
	a_write_once: assert property (link_enable_o
		|=> link_enable_o && $stable(ack_wait_limit_o)) else $error("control changed");
endmodule : dli_status_bank_chk
bind dli_status_bank dli_status_bank_chk dli_status_bank_chk_i (
	.clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .req_valid_i,
	.ack_valid_i, .ack_i, .start_o, .idle_cmd_o, .link_enable_o, .ack_wait_limit_o,
	.initiator_busy_o, .error_irq_o);
`default_nettype wire

// ===== dv/dli_status_bank_tb_top.sv
// Bench for the status bank: Wishbone tasks, request driver, target model.
// Assumes the bound checker and a sel of all lanes.
`default_nettype none
module dli_status_bank_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import dli_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc = 1'h0, stb = 1'h0, we = 1'h0, rqv = 1'h0, pin = 1'h0, aen = 1'h1;
	logic [5:0] adr = 6'h00;
	logic [31:0] dat = 32'h0, rdat, wdo;
	logic wack, lastc, ackv, st, idl, lclk, len, busy, eirq;
	logic [3:0] lim;
	dli_req_s rq = '0;
	dli_ack_s aw = '0, ackw;
	int err_total = 0, checked = 0;
	logic [7:0] ln [4] = '{8'hFE, 8'hFF, 8'hFF, 8'hFF};
	logic te [4] = '{1'h0, 1'h1, 1'h0, 1'h0};
	logic [1:0] pr [4] = '{2'h2, 2'h2, 2'h1, 2'h2};
	logic [7:0] ex [4] = '{8'hC0, 8'h88, 8'h84, 8'h90};
	// Clock of 4 ns
	always #2 clk_i = ~clk_i;
	dli_status_bank dli_status_bank_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(wdo), .wb_ack_o(wack), .req_valid_i(rqv), .req_i(rq),
		.last_cycle_i(lastc), .ack_valid_i(ackv), .ack_i(ackw), .start_o(st),
		.idle_cmd_o(idl), .link_clock_i(lclk), .target_irq_pin_i(pin),
		.link_enable_o(len), .ack_wait_limit_o(lim), .initiator_busy_o(busy),
		.error_irq_o(eirq));
	dli_target_model dli_target_model_i (.clk_i(clk_i), .start_i(st), .busy_i(busy),
		.ack_en_i(aen), .word_i(aw), .last_o(lastc), .ack_valid_o(ackv), .ack_o(ackw),
		.link_clock_o(lclk));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// One classic cycle, held until ack is sampled high at a rising edge
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do
			@(posedge clk_i);
		while (wack !== 1'h1 && ++t < 40);
		rdat = wdo;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (t >= 40)
			err_total++;
	endtask : wb
	task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'h0, a, 8'h00);
		chk(rdat & m, e);
	endtask : rd
	task automatic req(input dli_req_s r);
		@(posedge clk_i);
		rqv <= 1'h1;
		rq <= r;
		@(posedge clk_i);
		rqv <= 1'h0;
	endtask : req
	task automatic idle;
		int t;
		t = 0;
		do
			@(negedge clk_i);
		while (busy !== 1'h0 && ++t < 500);
		if (t >= 500)
			err_total++;
	endtask : idle
	task automatic results;
		$display("checked %0d, err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(6'h08, 32'hFFFFFFFF, 32'h0);
		rd(6'h0C, 32'hFFFFFFFF, 32'h0);
		rd(6'h10, 32'hFFFFFFFF, 32'h0);
		rd(6'h20, 32'hFFFFFFFF, 32'h0);
		wb(1'h1, 6'h00, 8'h81);
		wb(1'h1, 6'h00, 8'h05);
		chk({27'h0, len, lim}, 32'h11);
		$display("reset and setup done");
		aw <= {8'hFF, 1'h0, 2'h2, 2'h2};
		req(11'h6A5);
		rd(6'h0C, 32'hFF, 32'h40);
		idle();
		rd(6'h08, 32'hFF, 32'h02);
		rd(6'h10, 32'hFFFFFFFF, 32'hC0A5);
		rd(6'h0C, 32'hFF, 32'h0);
		$display("clean transfer done");
		for (int i = 0; i < 4; i++)
		begin
			aw <= {ln[i], te[i], pr[i], 2'h2};
			aen <= (i != 3);
			req({3'h1, 6'h04, i[1:0]});
			idle();
			rd(6'h08, 32'hFC, {24'h0, ex[i]});
			chk({31'h0, eirq}, 32'h1);
			req(11'h7EE);
			rd(6'h08, 32'hFC, {24'h0, ex[i] | 8'h20});
			rd(6'h10, 32'hFFFFFFFF, {16'h0, 8'h10, 6'h04, i[1:0]});
			wb(1'h1, 6'h08, 8'h7F);
			rd(6'h08, 32'hFC, {24'h0, ex[i] | 8'h20});
			wb(1'h1, 6'h08, 8'h80);
			rd(6'h08, 32'hFC, 32'h0);
		end
		$display("error cases done");
		pin <= 1'h1;
		repeat (4) @(posedge clk_i);
		rd(6'h0C, 32'h80, 32'h80);
		wb(1'h1, 6'h0C, 8'h00);
		rd(6'h0C, 32'h80, 32'h80);
		pin <= 1'h0;
		repeat (4) @(posedge clk_i);
		rd(6'h0C, 32'h80, 32'h0);
		$display("pin mirror done");
		results();
	end
	// Watchdog well past the expected run
	initial
	begin
		#100000;
		err_total++;
		results();
	end
endmodule : dli_status_bank_tb_top
`default_nettype wire
